// ---- rtl/fpd_pll_cfg.v ----
`timescale 1ns/1ps
`include "fpd_pll_defines.vh"

module fpd_pll_cfg #(
  parameter FW = `FPD_FRAC_W,
  parameter NW = `FPD_INT_W,
  parameter DW = `FPD_FACTOR_W
) (
  // Clock (oscillator reference) and reset
  input  wire          clk,
  input  wire          reset,
  // Control port
  input  wire [7:0]    reg_addr,
  input  wire [7:0]    reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [7:0]    reg_rdata_r,
  // Receiver side
  input  wire          rx_enabled,
  input  wire [NW-1:0] rx_int_mult,
  input  wire [FW-1:0] rx_frac_mult,
  input  wire [1:0]    rx_post_div_sel,
  // Synthesiser core
  input  wire          synth_tick,
  output reg           pll_ref_tick_r,
  output reg  [NW-1:0] applied_int_r,
  output reg  [FW-1:0] applied_frac_r,
  output reg           applied_fractional_r,
  // Divided clocks
  output reg  [DW-1:0] master_factor_r,
  output reg  [DW-1:0] aux_factor_r,
  output reg           divided_master_clock_r,
  output reg           divided_aux_clock_r,
  output reg           master_tick_r,
  output reg           aux_tick_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields

  reg [7:0]    frac_lo_r;
  reg [7:0]    frac_mid_r;
  reg [5:0]    frac_hi_r;
  reg [NW-1:0] int_mult_r;
  reg          input_halving_sel_r;
  reg [1:0]    post_div_sel_r;
  reg          fractional_mode_en_r;
  reg          master_branch_div_sel_r;
  reg [1:0]    aux_branch_div_sel_r;
  reg          halve_phase_r;

  wire [FW-1:0] user_frac = {frac_hi_r, frac_mid_r, frac_lo_r};
  wire          wr_ctl    = reg_wr && (reg_addr == `FPD_ADDR_POSTDIV_MODE);

  // Held until rewritten, defaults on reset
  always @(posedge clk)
  begin
    if (reset)
    begin
      frac_lo_r               <= `FPD_RST_FRAC_LO;
      frac_mid_r              <= `FPD_RST_FRAC_MID;
      frac_hi_r               <= `FPD_RST_FRAC_HI;
      int_mult_r              <= `FPD_RST_INT;
      input_halving_sel_r     <= `FPD_RST_HALVING;
      post_div_sel_r          <= `FPD_RST_POSTDIV;
      fractional_mode_en_r    <= `FPD_RST_FRACTIONAL_MODE_EN;
      master_branch_div_sel_r <= `FPD_RST_MASTER_DIV;
      aux_branch_div_sel_r    <= `FPD_RST_AUX_DIV;
    end
    else
    begin
      if (reg_wr && reg_addr == `FPD_ADDR_FRAC_LO)
        frac_lo_r <= reg_wdata;
      if (reg_wr && reg_addr == `FPD_ADDR_FRAC_MID)
        frac_mid_r <= reg_wdata;
      if (reg_wr && reg_addr == `FPD_ADDR_FRAC_HI)
        frac_hi_r <= reg_wdata[`FPD_FRAC_HI_MSB:0];
      if (reg_wr && reg_addr == `FPD_ADDR_INT_INPUT_HALVING_SEL)
      begin
        int_mult_r          <= reg_wdata[`FPD_INT_MSB:`FPD_INT_LSB];
        input_halving_sel_r <= reg_wdata[`FPD_HALVING_BIT];
      end
      if (wr_ctl)
      begin
        fractional_mode_en_r    <= reg_wdata[`FPD_FRACTIONAL_MODE_EN_BIT];
        master_branch_div_sel_r <= reg_wdata[`FPD_MASTER_DIV_BIT];
        aux_branch_div_sel_r    <= reg_wdata[`FPD_AUX_DIV_MSB:`FPD_AUX_DIV_LSB];
      end
      // Hardware update wins over a same-cycle software write
      if (rx_enabled)
        post_div_sel_r <= rx_post_div_sel;
      else if (wr_ctl)
        post_div_sel_r <= reg_wdata[`FPD_POSTDIV_MSB:`FPD_POSTDIV_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back

  always @(posedge clk)
  begin
    if (reset)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `FPD_ADDR_FRAC_LO:      reg_rdata_r <= frac_lo_r;
        `FPD_ADDR_FRAC_MID:     reg_rdata_r <= frac_mid_r;
        `FPD_ADDR_FRAC_HI:      reg_rdata_r <= {2'h0, frac_hi_r};
        `FPD_ADDR_INT_INPUT_HALVING_SEL: reg_rdata_r <= {3'h0, input_halving_sel_r, int_mult_r};
        `FPD_ADDR_POSTDIV_MODE: reg_rdata_r <= {2'h0, aux_branch_div_sel_r, master_branch_div_sel_r,
                                                fractional_mode_en_r, post_div_sel_r};
        default:                reg_rdata_r <= 8'h00; // Unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pre-scale: reference tick every cycle, or every second cycle

  always @(posedge clk)
  begin
    if (reset)
    begin
      halve_phase_r  <= 1'b0;
      pll_ref_tick_r <= 1'b0;
    end
    else
    begin
      halve_phase_r  <= ~halve_phase_r;
      pll_ref_tick_r <= input_halving_sel_r ? halve_phase_r : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied multiplier: receiver owns it while enabled

  always @(posedge clk)
  begin
    if (reset)
    begin
      applied_int_r        <= `FPD_RST_INT;
      applied_frac_r       <= {`FPD_RST_FRAC_HI, `FPD_RST_FRAC_MID, `FPD_RST_FRAC_LO};
      applied_fractional_r <= `FPD_RST_FRACTIONAL_MODE_EN;
    end
    else if (rx_enabled)
    begin
      // Receiver path always runs fractional; software must keep the bit set too
      applied_int_r        <= rx_int_mult;
      applied_frac_r       <= rx_frac_mult;
      applied_fractional_r <= 1'b1;
    end
    else
    begin
      applied_int_r        <= int_mult_r;
      applied_frac_r       <= fractional_mode_en_r ? user_frac : {FW{1'b0}};
      applied_fractional_r <= fractional_mode_en_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Post-divider factors

  // Base master factor 2, 4, 8, 12 per select code
  function [DW-1:0] master_factor;
    input [1:0] sel;
    input       dbl;
    reg   [DW-1:0] base;
    begin
      base = {DW{1'b0}};
      case (sel)
        2'h0:    base = `FPD_BASE_DIV0;
        2'h1:    base = `FPD_BASE_DIV1;
        2'h2:    base = `FPD_BASE_DIV2;
        2'h3:    base = `FPD_BASE_DIV3;
        default: base = `FPD_BASE_DIV2;
      endcase
      master_factor = dbl ? {base[DW-2:0], 1'b0} : base;
    end
  endfunction

  // Aux factor: half the master base scaled by 2^code, floor of 2
  function [DW-1:0] aux_factor;
    input [1:0] sel;
    input [1:0] code;
    reg   [DW-1:0] half;
    reg   [DW-1:0] f;
    begin
      half = master_factor(sel, 1'b0) >> 1;
      f    = half << code;
      aux_factor = (f < `FPD_MIN_DIV) ? `FPD_MIN_DIV : f;
    end
  endfunction

  always @(posedge clk)
  begin
    if (reset)
    begin
      master_factor_r <= master_factor(`FPD_RST_POSTDIV, `FPD_RST_MASTER_DIV);
      aux_factor_r    <= aux_factor(`FPD_RST_POSTDIV, `FPD_RST_AUX_DIV);
    end
    else
    begin
      master_factor_r <= master_factor(post_div_sel_r, master_branch_div_sel_r);
      aux_factor_r    <= aux_factor(post_div_sel_r, aux_branch_div_sel_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Branch dividers off the synthesised clock ticks

  wire m_pulse;
  wire m_level;
  wire a_pulse;
  wire a_level;

  fpd_tick_div #(.W(DW)) u_master_div (
    .clk     (clk),
    .reset   (reset),
    .tick_in (synth_tick),
    .factor  (master_factor_r),
    .pulse_r (m_pulse),
    .level_r (m_level)
  );

  fpd_tick_div #(.W(DW)) u_aux_div (
    .clk     (clk),
    .reset   (reset),
    .tick_in (synth_tick),
    .factor  (aux_factor_r),
    .pulse_r (a_pulse),
    .level_r (a_level)
  );

  // Re-register so top outputs come straight from local flops
  always @(posedge clk)
  begin
    if (reset)
    begin
      divided_master_clock_r <= 1'b0;
      divided_aux_clock_r    <= 1'b0;
      master_tick_r          <= 1'b0;
      aux_tick_r             <= 1'b0;
    end
    else
    begin
      divided_master_clock_r <= m_level;
      divided_aux_clock_r    <= a_level;
      master_tick_r          <= m_pulse;
      aux_tick_r             <= a_pulse;
    end
  end

endmodule // fpd_pll_cfg

// ---- rtl/fpd_pll_defines.vh ----
`ifndef FPD_PLL_DEFINES_VH
`define FPD_PLL_DEFINES_VH

// Register offsets on the control port
`define FPD_ADDR_FRAC_LO        8'h03
`define FPD_ADDR_FRAC_MID       8'h04
`define FPD_ADDR_FRAC_HI        8'h05
`define FPD_ADDR_INT_INPUT_HALVING_SEL   8'h06
`define FPD_ADDR_POSTDIV_MODE   8'h07

// Field positions
`define FPD_INT_MSB             3
`define FPD_INT_LSB             0
`define FPD_HALVING_BIT         4
`define FPD_FRAC_HI_MSB         5
`define FPD_POSTDIV_MSB         1
`define FPD_POSTDIV_LSB         0
`define FPD_FRACTIONAL_MODE_EN_BIT          2
`define FPD_MASTER_DIV_BIT      3
`define FPD_AUX_DIV_MSB         5
`define FPD_AUX_DIV_LSB         4

// Widths
`define FPD_FRAC_W              22
`define FPD_INT_W               4
`define FPD_FACTOR_W            6

// Post-divider base factors per select code, and the aux floor
`define FPD_BASE_DIV0           6'h02
`define FPD_BASE_DIV1           6'h04
`define FPD_BASE_DIV2           6'h08
`define FPD_BASE_DIV3           6'h0c
`define FPD_MIN_DIV             6'h02

// Reset values
`define FPD_RST_FRAC_LO         8'h21
`define FPD_RST_FRAC_MID        8'hfd
`define FPD_RST_FRAC_HI         6'h36
`define FPD_RST_INT             4'h7
`define FPD_RST_HALVING         1'h0
`define FPD_RST_POSTDIV         2'h2
`define FPD_RST_FRACTIONAL_MODE_EN          1'h1
`define FPD_RST_MASTER_DIV      1'h0
`define FPD_RST_AUX_DIV         2'h1

`endif

// ---- rtl/fpd_tick_div.v ----
`timescale 1ns/1ps
// Divides a tick stream by an even factor into a pulse and a square level
module fpd_tick_div #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset,
  // Source ticks and divide factor
  input  wire         tick_in,
  input  wire [W-1:0] factor,
  // Divided outputs
  output reg          pulse_r,
  output reg          level_r
);

  reg  [W-1:0] cnt_r;
  wire [W-1:0] last    = factor - {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] half_m1 = {1'b0, factor[W-1:1]} - {{(W-1){1'b0}}, 1'b1};

  // Wrap on >= so a factor shrinking mid-count cannot run away
  always @(posedge clk)
  begin
    if (reset)
    begin
      cnt_r   <= {W{1'b0}};
      pulse_r <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      pulse_r <= 1'b0;
      if (tick_in)
      begin
        if (cnt_r >= last)
        begin
          cnt_r   <= {W{1'b0}};
          pulse_r <= 1'b1;
          level_r <= 1'b0;
        end
        else
        begin
          cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
          if (cnt_r == half_m1)
            level_r <= 1'b1;
        end
      end
    end
  end

endmodule // fpd_tick_div

// ---- test/fpd_pll_cfg_assertions.sv ----
`timescale 1ns/1ps
module fpd_pll_cfg_assertions (
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // Control port
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata_r,
  // Receiver and synthesiser side
  input wire        rx_enabled,
  input wire [3:0]  rx_int_mult,
  input wire        pll_ref_tick_r,
  input wire [3:0]  applied_int_r,
  input wire [21:0] applied_frac_r,
  input wire        applied_fractional_r,
  input wire [5:0]  master_factor_r,
  input wire [5:0]  aux_factor_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Expected branch factors
  function automatic [5:0] mexp(input [1:0] s, input d);
    mexp = (s == 2'h3 ? 6'h0c : 6'h02 << s) << d;
  endfunction
  function automatic [5:0] aexp(input [1:0] s, input [1:0] c);
    aexp = (s == 2'h0 && c == 2'h0) ? 6'h02 : ((s == 2'h3 ? 6'h06 : 6'h01 << s) << c);
  endfunction
  // Write strobes for registers 06 and 07
  wire w6 = reg_wr && reg_addr == 8'h06;
  wire w7 = reg_wr && reg_addr == 8'h07;
  ////////////////////////////////////////
  AST_RD_UNMAPPED: assert property (reg_rd && (reg_addr < 8'h03 || reg_addr > 8'h07) |=> reg_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata_r))
    else $error("read data moved without a read");
  AST_INT_NO_FRAC: assert property (!applied_fractional_r |-> applied_frac_r == 22'h0)
    else $error("fraction applied in integer mode");
  AST_RX_FRAC: assert property (rx_enabled |=> applied_fractional_r)
    else $error("receiver mode not fractional");
  AST_RX_INT: assert property (rx_enabled |=> applied_int_r == $past(rx_int_mult))
    else $error("receiver integer not applied");
  AST_REF_FULL: assert property (w6 && !reg_wdata[4] ##1 !w6 |=> pll_ref_tick_r [*2])
    else $error("undivided reference tick missing");
  AST_REF_HALF: assert property (w6 && reg_wdata[4] ##1 !w6 ##1 !w6 |=> pll_ref_tick_r != $past(pll_ref_tick_r))
    else $error("halved reference tick not alternating");
  AST_MASTER: assert property (w7 && !rx_enabled ##1 (!w7 && !rx_enabled) [*2] |=>
    master_factor_r == mexp($past(reg_wdata[1:0], 3), $past(reg_wdata[3], 3)))
    else $error("master factor wrong");
  AST_AUX: assert property (w7 && !rx_enabled ##1 (!w7 && !rx_enabled) [*2] |=>
    aux_factor_r == aexp($past(reg_wdata[1:0], 3), $past(reg_wdata[5:4], 3)))
    else $error("aux factor wrong");
  // Main scenarios reached
  cover property (rx_enabled ##1 !rx_enabled);
  cover property (w6 && reg_wdata[4]);
  cover property (reg_rd && reg_addr == 8'h07);
endmodule // fpd_pll_cfg_assertions

bind fpd_pll_cfg fpd_pll_cfg_assertions i_fpd_pll_cfg_assertions (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_r, .rx_enabled, .rx_int_mult, .pll_ref_tick_r, .applied_int_r, .applied_frac_r,
  .applied_fractional_r, .master_factor_r, .aux_factor_r);

// ---- test/fpd_pll_cfg_tb.sv ----
`timescale 1ns/1ps
module fpd_pll_cfg_tb;
  // Inputs driven at the falling edge
  reg         clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rx_enabled = 1'b0, synth_tick = 1'b0;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, f6, f7, v;
  reg  [3:0]  rx_int_mult = 4'h9;
  reg  [21:0] rx_frac_mult = 22'h0, fr;
  reg  [1:0]  rx_post_div_sel = 2'h1;
  wire [7:0]  reg_rdata_r;
  wire        pll_ref_tick_r, applied_fractional_r, mclk, aclk, master_tick_r, aux_tick_r;
  wire [3:0]  applied_int_r;
  wire [21:0] applied_frac_r;
  wire [5:0]  master_factor_r, aux_factor_r;
  reg         mp, ap;
  integer     errors = 0, cmp_count = 0, cycles = 0, seed = 49, tseed = 49, i, t, p, q, r, s;
  ////////////////////////////////////////
  fpd_pll_cfg i_fpd_pll_cfg (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .rx_enabled(rx_enabled),
    .rx_int_mult(rx_int_mult), .rx_frac_mult(rx_frac_mult), .rx_post_div_sel(rx_post_div_sel),
    .synth_tick(synth_tick), .pll_ref_tick_r(pll_ref_tick_r), .applied_int_r(applied_int_r),
    .applied_frac_r(applied_frac_r), .applied_fractional_r(applied_fractional_r),
    .master_factor_r(master_factor_r), .aux_factor_r(aux_factor_r), .divided_master_clock_r(mclk),
    .divided_aux_clock_r(aclk), .master_tick_r(master_tick_r), .aux_tick_r(aux_tick_r));
  // Clock, random synthesiser ticks and hang guard
  always #25 clk = ~clk;
  always @(negedge clk) synth_tick <= $random(tseed);
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      errors = errors + 1;
      close_out;
    end
  end
  ////////////////////////////////////////
  // Expected factors, kept apart from the design
  function automatic [5:0] mexp(input [1:0] s, input d);
    mexp = (s == 2'h3 ? 6'h0c : 6'h02 << s) << d;
  endfunction
  function automatic [5:0] aexp(input [1:0] s, input [1:0] c);
    aexp = (s == 2'h0 && c == 2'h0) ? 6'h02 : ((s == 2'h3 ? 6'h06 : 6'h01 << s) << c);
  endfunction
  // Integer and fraction from a ratio given in thousandths, fraction truncated
  function automatic [25:0] nk(input integer milli);
    reg [63:0] k;
    reg [31:0] n;
    begin
      n = milli / 1000;
      k = (milli % 1000) * 64'h400000 / 1000;
      nk = {n[3:0], k[21:0]};
    end
  endfunction
  // Compare, bus cycles and verdict
  task chk(input string nm, input [23:0] e, input [23:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // Data is looked at one extra cycle late; it holds until the next read anyway
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk("rdata", e, reg_rdata_r);
  endtask
  task close_out;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    rd(8'h03, 8'h21);
    rd(8'h04, 8'hfd);
    rd(8'h05, 8'h36);
    rd(8'h06, 8'h07);
    rd(8'h07, 8'h16);
    chk("int", 4'h7, applied_int_r);
    chk("frac", 22'h36fd21, applied_frac_r);
    chk("mfac", 6'h08, master_factor_r);
    chk("afac", 6'h08, aux_factor_r);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h00);
    rd(8'h00, 8'h00);
    // Every post-divider, mode and branch code with random legal multipliers
    for (i = 0; i < 64; i = i + 1)
    begin
      v = $random(seed);
      f6 = {v[7:4], 4'h5 + {1'b0, v[2:0]}};
      f7 = {v[1:0], i[5:0]};
      fr = $random(seed);
      wr(8'h06, f6);
      wr(8'h03, fr[7:0]);
      wr(8'h04, fr[15:8]);
      wr(8'h05, {v[3:2], fr[21:16]});
      wr(8'h07, f7);
      rd(8'h06, f6 & 8'h1f);
      rd(8'h05, {2'h0, fr[21:16]});
      rd(8'h07, f7 & 8'h3f);
      chk("int", f6[3:0], applied_int_r);
      chk("frac", f7[2] ? fr : 22'h0, applied_frac_r);
      chk("mode", f7[2], applied_fractional_r);
      chk("mfac", mexp(f7[1:0], f7[3]), master_factor_r);
      chk("afac", aexp(f7[1:0], f7[5:4]), aux_factor_r);
      v[0] = pll_ref_tick_r;
      @(negedge clk);
      chk("ref", 1'b1, f6[4] ? v[0] ^ pll_ref_tick_r : v[0] & pll_ref_tick_r);
    end
    // Directed ratio 8.192: integer 8 at the sweet spot, fractional mode kept on
    {v[3:0], fr} = nk(8192);
    wr(8'h06, {4'h0, v[3:0]});
    wr(8'h03, fr[7:0]);
    wr(8'h04, fr[15:8]);
    wr(8'h05, {2'h0, fr[21:16]});
    wr(8'h07, 8'h16);
    rd(8'h07, 8'h16);
    chk("int", 4'h8, applied_int_r);
    chk("frac", 22'h0c49ba, applied_frac_r);
    chk("mfac", 6'h08, master_factor_r);
    // Receiver mode overrides the programmed values; software keeps fractional on
    rx_enabled = 1'b1;
    rx_frac_mult = $random(seed);
    wr(8'h07, 8'h0c);
    rd(8'h07, 8'h0d);
    chk("int", rx_int_mult, applied_int_r);
    chk("frac", rx_frac_mult, applied_frac_r);
    chk("mode", 1'b1, applied_fractional_r);
    chk("mfac", mexp(2'h1, 1'b1), master_factor_r);
    rx_enabled = 1'b0;
    // Divided clocks: pulse counts against synthesiser ticks, less than two periods short or at most one period over
    wr(8'h07, 8'h26);
    repeat (4) @(negedge clk);
    t = 0;
    p = 0;
    q = 0;
    r = 0;
    s = 0;
    mp = mclk;
    ap = aclk;
    repeat (600)
    begin
      @(negedge clk);
      t = t + synth_tick;
      p = p + master_tick_r;
      q = q + aux_tick_r;
      r = r + (mclk & ~mp);
      s = s + (aclk & ~ap);
      mp = mclk;
      ap = aclk;
    end
    chk("mdiv", 1'b1, p * 8 + 16 > t && p * 8 < t + 9);
    chk("adiv", 1'b1, q * 16 + 32 > t && q * 16 < t + 17);
    // Square wave rises once per divided period, so rises track the ticks
    chk("mclk", 1'b1, r <= p + 1 && p <= r + 1);
    chk("aclk", 1'b1, s <= q + 1 && q <= s + 1);
    // Mid-run reset brings the written fields back to their defaults
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    rd(8'h06, 8'h07);
    rd(8'h07, 8'h16);
    chk("int", 4'h7, applied_int_r);
    close_out;
  end
endmodule // fpd_pll_cfg_tb
